// ===== rtl/pio_ports.sv
// parallel ports b, c and d with apb register access
//
// The APB slave port was chosen for this implementation.
`include "pio_params.svh"
`timescale 1ns/10ps
`default_nettype none

module pio_ports (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PIO_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // port b pins
    input wire logic [7:0] portb_pin_in,
    output logic [7:0] portb_pin_out,
    output logic [7:0] portb_pin_oe,
    // port c pins
    input wire logic [6:0] portc_pin_in,
    output logic [6:0] portc_pin_out,
    output logic [6:0] portc_pin_oe,
    output logic [6:0] portc_pullup_on,
    // port d pins
    input wire logic [7:0] portd_pin_in,
    output logic [7:0] portd_pin_out,
    output logic [7:0] portd_pin_oe,
    output logic [7:0] portd_pullup_on,
    // serial peripheral side of port d
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe,
    input wire logic serial_mosi_out,
    input wire logic serial_mosi_oe,
    input wire logic serial_miso_out,
    input wire logic serial_miso_oe,
    output logic serial_clock_pin,
    output logic serial_mosi_pin,
    output logic serial_miso_pin,
    output logic serial_ss_pin,
    output logic serial_periph_enable,
    output logic serial_periph_master_select,
    // timer channels of port d (edge_level_select nonzero means timer owns pin)
    input wire logic [1:0] timer1_ch0_edge_level_select,
    input wire logic [1:0] timer1_ch1_edge_level_select,
    input wire logic [1:0] timer2_ch0_edge_level_select,
    input wire logic [1:0] timer2_ch1_edge_level_select,
    input wire logic [3:0] timer_ch_out,
    input wire logic [3:0] timer_ch_oe,
    output logic timer1_channel0_pin,
    output logic timer1_channel1_pin,
    output logic timer2_channel0_pin,
    output logic timer2_channel1_pin
);

    pio_pkg::pio_state_t st_reg;
    pio_pkg::pio_state_t st_next;
    logic [3:0] timer_owns;
    logic [7:0] periph_owns;
    logic [7:0] periph_out;
    logic [7:0] periph_oe;
    logic [3:0] widx;
    logic wr_en;
    logic rd_en;
    logic mapped;
    // whole control reset word, so single fields can be picked from it
    localparam logic [7:0] CTRL_RESET = `PIO_CTRL_RESET;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // read mux: latch where output, synchronised pin where input
    function automatic logic [7:0] pio_read_mux(input logic [7:0] latch, input logic [7:0] dir,
                                                input logic [7:0] pin);
        pio_read_mux = (latch & dir) | (pin & ~dir);
    endfunction

    // byte-lane-0 write merge
    function automatic logic [7:0] pio_merge(input logic [7:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
        pio_merge = strb[0] ? wd[7:0] : old;
    endfunction

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && clk_en;
    assign rd_en = psel && !penable && !pwrite;
    assign widx = paddr[5:2];

    always_comb begin
        if (paddr[`PIO_ADDR_WIDTH-1:6] != '0 || paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (widx == `PIO_IDX_PORTB_LATCH || widx == `PIO_IDX_PORTC_LATCH ||
                     widx == `PIO_IDX_PORTD_LATCH || widx == `PIO_IDX_PORTB_DIR ||
                     widx == `PIO_IDX_PORTC_DIR || widx == `PIO_IDX_PORTD_DIR ||
                     widx == `PIO_IDX_PORTC_PUE || widx == `PIO_IDX_PORTD_PUE ||
                     widx == `PIO_IDX_PERIPH_CTRL) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = psel && penable && !mapped;

    // ----------------------------------------
    // pin ownership
    // ----------------------------------------
    assign timer_owns[0] = timer1_ch0_edge_level_select != 2'h0;
    assign timer_owns[1] = timer1_ch1_edge_level_select != 2'h0;
    assign timer_owns[2] = timer2_ch0_edge_level_select != 2'h0;
    assign timer_owns[3] = timer2_ch1_edge_level_select != 2'h0;

    always_comb begin
        periph_owns = 8'h00;
        periph_out = 8'h00;
        periph_oe = 8'h00;
        // serial pins leave port control only while enabled
        periph_owns[`PIO_SCK_BIT] = st_reg.serial_periph_enable;
        periph_owns[`PIO_MOSI_BIT] = st_reg.serial_periph_enable;
        periph_owns[`PIO_MISO_BIT] = st_reg.serial_periph_enable;
        periph_owns[`PIO_SS_BIT] = st_reg.serial_periph_enable && !st_reg.serial_periph_master_select;
        periph_out[`PIO_SCK_BIT] = serial_clock_out;
        periph_oe[`PIO_SCK_BIT] = serial_clock_oe;
        periph_out[`PIO_MOSI_BIT] = serial_mosi_out;
        periph_oe[`PIO_MOSI_BIT] = serial_mosi_oe;
        periph_out[`PIO_MISO_BIT] = serial_miso_out;
        periph_oe[`PIO_MISO_BIT] = serial_miso_oe;
        periph_owns[7:`PIO_TIMER_LSB] = timer_owns;
        periph_out[7:`PIO_TIMER_LSB] = timer_ch_out;
        periph_oe[7:`PIO_TIMER_LSB] = timer_ch_oe;
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    assign portb_pin_out = st_reg.portb_latch;
    assign portb_pin_oe = st_reg.portb_direction_bits;
    assign portc_pin_out = st_reg.portc_latch;
    assign portc_pin_oe = st_reg.portc_direction_bits;
    assign portc_pullup_on = st_reg.portc_pullup_enable & ~st_reg.portc_direction_bits;
    assign portd_pin_out = (periph_out & periph_owns) | (st_reg.portd_latch & ~periph_owns);
    assign portd_pin_oe = (periph_oe & periph_owns) | (st_reg.portd_direction_bits & ~periph_owns);
    assign portd_pullup_on = st_reg.portd_pullup_enable & ~portd_pin_oe;
    assign serial_ss_pin = st_reg.portd_sync2[`PIO_SS_BIT];
    assign serial_miso_pin = st_reg.portd_sync2[`PIO_MISO_BIT];
    assign serial_mosi_pin = st_reg.portd_sync2[`PIO_MOSI_BIT];
    assign serial_clock_pin = st_reg.portd_sync2[`PIO_SCK_BIT];
    assign timer1_channel0_pin = st_reg.portd_sync2[`PIO_TIMER_LSB];
    assign timer1_channel1_pin = st_reg.portd_sync2[`PIO_TIMER_LSB+1];
    assign timer2_channel0_pin = st_reg.portd_sync2[`PIO_TIMER_LSB+2];
    assign timer2_channel1_pin = st_reg.portd_sync2[`PIO_TIMER_LSB+3];
    assign serial_periph_enable = st_reg.serial_periph_enable;
    assign serial_periph_master_select = st_reg.serial_periph_master_select;
    assign prdata = st_reg.prdata;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.portb_sync1 = portb_pin_in;
        st_next.portb_sync2 = st_reg.portb_sync1;
        st_next.portc_sync1 = portc_pin_in;
        st_next.portc_sync2 = st_reg.portc_sync1;
        st_next.portd_sync1 = portd_pin_in;
        st_next.portd_sync2 = st_reg.portd_sync1;
        // read data captured in setup, held through access
        if (rd_en) begin
            st_next.prdata = 32'h0000_0000;
            if (widx == `PIO_IDX_PORTB_LATCH) begin
                st_next.prdata[7:0] = pio_read_mux(st_reg.portb_latch, st_reg.portb_direction_bits,
                                                   st_reg.portb_sync2);
            end else if (widx == `PIO_IDX_PORTC_LATCH) begin
                st_next.prdata[7:0] = pio_read_mux({1'b0, st_reg.portc_latch},
                                                   {1'b0, st_reg.portc_direction_bits},
                                                   {1'b0, st_reg.portc_sync2});
            end else if (widx == `PIO_IDX_PORTD_LATCH) begin
                st_next.prdata[7:0] = pio_read_mux(st_reg.portd_latch, st_reg.portd_direction_bits,
                                                   st_reg.portd_sync2);
            end else if (widx == `PIO_IDX_PORTB_DIR) begin
                st_next.prdata[7:0] = st_reg.portb_direction_bits;
            end else if (widx == `PIO_IDX_PORTC_DIR) begin
                st_next.prdata[7:0] = {1'b0, st_reg.portc_direction_bits};
            end else if (widx == `PIO_IDX_PORTD_DIR) begin
                st_next.prdata[7:0] = st_reg.portd_direction_bits;
            end else if (widx == `PIO_IDX_PORTC_PUE) begin
                st_next.prdata[7:0] = {1'b0, st_reg.portc_pullup_enable};
            end else if (widx == `PIO_IDX_PORTD_PUE) begin
                st_next.prdata[7:0] = st_reg.portd_pullup_enable;
            end else if (widx == `PIO_IDX_PERIPH_CTRL) begin
                st_next.prdata[`PIO_CTRL_SPE_BIT] = st_reg.serial_periph_enable;
                st_next.prdata[`PIO_CTRL_MSTR_BIT] = st_reg.serial_periph_master_select;
            end else begin
                st_next.prdata = 32'h0000_0000;
            end
        end
        // writes; latches accept them whatever the direction
        if (wr_en && mapped) begin
            if (widx == `PIO_IDX_PORTB_LATCH) begin
                st_next.portb_latch = pio_merge(st_reg.portb_latch, pwdata, pstrb);
            end else if (widx == `PIO_IDX_PORTC_LATCH) begin
                st_next.portc_latch = 7'(pio_merge({1'b0, st_reg.portc_latch}, pwdata,
                                                   pstrb) & `PIO_PORTC_MASK);
            end else if (widx == `PIO_IDX_PORTD_LATCH) begin
                st_next.portd_latch = pio_merge(st_reg.portd_latch, pwdata, pstrb);
            end else if (widx == `PIO_IDX_PORTB_DIR) begin
                st_next.portb_direction_bits = pio_merge(st_reg.portb_direction_bits, pwdata, pstrb);
            end else if (widx == `PIO_IDX_PORTC_DIR) begin
                st_next.portc_direction_bits = 7'(pio_merge({1'b0, st_reg.portc_direction_bits}, pwdata,
                                                            pstrb) & `PIO_PORTC_MASK);
            end else if (widx == `PIO_IDX_PORTD_DIR) begin
                st_next.portd_direction_bits = pio_merge(st_reg.portd_direction_bits, pwdata, pstrb);
            end else if (widx == `PIO_IDX_PORTC_PUE) begin
                st_next.portc_pullup_enable = 7'(pio_merge({1'b0, st_reg.portc_pullup_enable}, pwdata,
                                                           pstrb) & `PIO_PORTC_MASK);
            end else if (widx == `PIO_IDX_PORTD_PUE) begin
                st_next.portd_pullup_enable = pio_merge(st_reg.portd_pullup_enable, pwdata, pstrb);
            end else if (widx == `PIO_IDX_PERIPH_CTRL) begin
                if (pstrb[0]) begin
                    st_next.serial_periph_enable = pwdata[`PIO_CTRL_SPE_BIT];
                    st_next.serial_periph_master_select = pwdata[`PIO_CTRL_MSTR_BIT];
                end
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // latches keep their value across reset
            st_reg.portb_latch <= st_reg.portb_latch;
            st_reg.portc_latch <= st_reg.portc_latch;
            st_reg.portd_latch <= st_reg.portd_latch;
            st_reg.portb_direction_bits <= `PIO_DIR_RESET;
            st_reg.portc_direction_bits <= 7'(`PIO_DIR_RESET);
            st_reg.portd_direction_bits <= `PIO_DIR_RESET;
            st_reg.portc_pullup_enable <= 7'(`PIO_PUE_RESET);
            st_reg.portd_pullup_enable <= `PIO_PUE_RESET;
            st_reg.serial_periph_enable <= CTRL_RESET[`PIO_CTRL_SPE_BIT];
            st_reg.serial_periph_master_select <= CTRL_RESET[`PIO_CTRL_MSTR_BIT];
            st_reg.portb_sync1 <= 8'h00;
            st_reg.portb_sync2 <= 8'h00;
            st_reg.portc_sync1 <= 7'h00;
            st_reg.portc_sync2 <= 7'h00;
            st_reg.portd_sync1 <= 8'h00;
            st_reg.portd_sync2 <= 8'h00;
            st_reg.prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

endmodule // pio_ports

`default_nettype wire

// ===== rtl/pio_params.svh
// register offsets, widths and reset values of the parallel port block
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

// ----------------------------------------
// register word indices (byte address is index times four)
// ----------------------------------------
`define PIO_IDX_PORTB_LATCH 4'h1
`define PIO_IDX_PORTC_LATCH 4'h2
`define PIO_IDX_PORTD_LATCH 4'h3
`define PIO_IDX_PORTB_DIR 4'h5
`define PIO_IDX_PORTC_DIR 4'h6
`define PIO_IDX_PORTD_DIR 4'h7
`define PIO_IDX_PORTC_PUE 4'h8
`define PIO_IDX_PORTD_PUE 4'h9
`define PIO_IDX_PERIPH_CTRL 4'hA
`define PIO_ADDR_WIDTH 12
`define PIO_ADDR_OF(idx) ({6'h00, (idx), 2'h0})

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PIO_DIR_RESET 8'h00
`define PIO_PUE_RESET 8'h00
`define PIO_CTRL_RESET 8'h00
`define PIO_CTRL_SPE_BIT 0
`define PIO_CTRL_MSTR_BIT 1
`define PIO_SS_BIT 0
`define PIO_MISO_BIT 1
`define PIO_MOSI_BIT 2
`define PIO_SCK_BIT 3
`define PIO_TIMER_LSB 4
`define PIO_PORTC_MASK 8'h7F

`endif

// ===== rtl/pio_pkg.sv
// types of the parallel port block
package pio_pkg;
    typedef struct packed {
        logic [7:0] portb_latch;
        logic [7:0] portb_direction_bits;
        logic [6:0] portc_latch;
        logic [6:0] portc_direction_bits;
        logic [6:0] portc_pullup_enable;
        logic [7:0] portd_latch;
        logic [7:0] portd_direction_bits;
        logic [7:0] portd_pullup_enable;
        logic serial_periph_enable;
        logic serial_periph_master_select;
        logic [6:0] portc_sync1;
        logic [6:0] portc_sync2;
        logic [7:0] portb_sync1;
        logic [7:0] portb_sync2;
        logic [7:0] portd_sync1;
        logic [7:0] portd_sync2;
        logic [31:0] prdata;
    } pio_state_t;
endpackage

// ===== tb/pio_ports_properties.sv
// assertion checker for the parallel port block
`include "pio_params.svh"
`timescale 1ns/10ps
`default_nettype none

module pio_ports_checker (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PIO_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic [7:0] portb_pin_out,
    input wire logic [7:0] portb_pin_oe,
    input wire logic [6:0] portc_pin_oe,
    input wire logic [6:0] portc_pullup_on,
    input wire logic [7:0] portd_pin_out,
    input wire logic [7:0] portd_pin_oe,
    input wire logic [7:0] portd_pullup_on,
    // peripherals
    input wire logic serial_clock_oe,
    input wire logic serial_periph_enable,
    input wire logic serial_periph_master_select,
    input wire logic [1:0] timer1_ch0_edge_level_select,
    input wire logic [3:0] timer_ch_out,
    input wire logic [3:0] timer_ch_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    logic [7:0] wbyte_reg;
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite && clk_en && pstrb[0];
    always_ff @(posedge clk_sys) begin
        wbyte_reg <= pwdata[7:0];
    end
    pready_up_a: assert property (disable iff (!rst_n) psel |-> pready)
        else $error("pready low during a transfer");
    err_in_access_a: assert property (disable iff (!rst_n) pslverr |-> psel && penable)
        else $error("error response outside access phase");
    dir_b_write_a: assert property (disable iff (!rst_n)
        wr_acc && paddr == `PIO_ADDR_OF(`PIO_IDX_PORTB_DIR) |=> portb_pin_oe == wbyte_reg)
        else $error("port b direction write not applied");
    latch_b_write_a: assert property (disable iff (!rst_n)
        wr_acc && paddr == `PIO_ADDR_OF(`PIO_IDX_PORTB_LATCH) |=> portb_pin_out == wbyte_reg)
        else $error("port b latch write not applied");
    reset_dir_a: assert property (!rst_n && clk_en |=> portb_pin_oe == 8'h00 && portc_pin_oe == 7'h00)
        else $error("direction bits not cleared by reset");
    c_pullup_off_a: assert property (disable iff (!rst_n) (portc_pullup_on & portc_pin_oe) == 7'h00)
        else $error("port c pullup on an output");
    d_pullup_off_a: assert property (disable iff (!rst_n) (portd_pullup_on & portd_pin_oe) == 8'h00)
        else $error("port d pullup on an output");
    slave_sel_a: assert property (disable iff (!rst_n)
        serial_periph_enable && !serial_periph_master_select |-> !portd_pin_oe[0])
        else $error("slave select driven by port");
    serial_clock_a: assert property (disable iff (!rst_n)
        serial_periph_enable |-> portd_pin_oe[3] == serial_clock_oe)
        else $error("serial clock drive not from peripheral");
    timer_pin_a: assert property (disable iff (!rst_n)
        timer1_ch0_edge_level_select != 2'h0 |-> portd_pin_oe[4] == timer_ch_oe[0] && portd_pin_out[4] == timer_ch_out[0])
        else $error("timer channel pin not owned by timer");
    cover property (disable iff (!rst_n) wr_acc);
    cover property (disable iff (!rst_n) serial_periph_enable && serial_periph_master_select);
    cover property (disable iff (!rst_n) pslverr);
endmodule // pio_ports_checker

bind pio_ports pio_ports_checker u_chk (.clk_sys, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .pslverr, .portb_pin_out, .portb_pin_oe, .portc_pin_oe, .portc_pullup_on, .portd_pin_out,
    .portd_pin_oe, .portd_pullup_on, .serial_clock_oe, .serial_periph_enable, .serial_periph_master_select,
    .timer1_ch0_edge_level_select, .timer_ch_out, .timer_ch_oe);
`default_nettype wire

// ===== tb/pio_pin_model.sv
// pin model: outside drivers and pullups resolving one port's lines
`timescale 1ns/10ps
`default_nettype none

module pio_pin_model #(
    parameter int W = 8
) (
    // clock
    input wire logic clk_sys,
    // device side
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pullup_on,
    // outside driver
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    // resolved level
    output logic [W-1:0] pin_level
);
    logic [W-1:0] last_reg = '0;
    always_ff @(posedge clk_sys) begin
        last_reg <= pin_level;
    end
    // an undriven line without pullup wanders rather than holding its value
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i]) begin
                pin_level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_val[i];
            end else if (pullup_on[i]) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = ~last_reg[i];
            end
        end
    end
endmodule // pio_pin_model
`default_nettype wire

// ===== tb/tb.sv
// testbench for the parallel port block
`include "pio_params.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("FAIL %0t got %h expected %h", $time, got, exp); end end

module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr;
    logic [31:0] prdata;
    logic [7:0] b_lvl, b_out, b_oe, d_lvl, d_out, d_oe, d_pu;
    logic [6:0] c_lvl, c_out, c_oe, c_pu;
    logic sck_out = 1'b0, sck_oe = 1'b0, mosi_out = 1'b0, mosi_oe = 1'b0, miso_out = 1'b0, miso_oe = 1'b0;
    logic [1:0] els = 2'h0, els1 = 2'h0, els2 = 2'h0, els3 = 2'h0;
    logic [6:0] c_ext = 7'h00, c_ext_en = 7'h00;
    logic [7:0] d_ext = 8'h00, d_ext_en = 8'h00;
    logic sck_pin, mosi_pin, miso_pin, ss_pin, spe_o, mstr_o;
    logic [3:0] t_pin;
    logic last_err = 1'b0;
    logic [3:0] t_out = 4'h0, t_oe = 4'h0;
    int failures = 0;
    int check_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    pio_ports dut (.clk_sys, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .pslverr, .prdata, .portb_pin_in(b_lvl), .portb_pin_out(b_out), .portb_pin_oe(b_oe),
        .portc_pin_in(c_lvl), .portc_pin_out(c_out), .portc_pin_oe(c_oe), .portc_pullup_on(c_pu),
        .portd_pin_in(d_lvl), .portd_pin_out(d_out), .portd_pin_oe(d_oe), .portd_pullup_on(d_pu),
        .serial_clock_out(sck_out), .serial_clock_oe(sck_oe), .serial_mosi_out(mosi_out),
        .serial_mosi_oe(mosi_oe), .serial_miso_out(miso_out), .serial_miso_oe(miso_oe),
        .serial_clock_pin(sck_pin), .serial_mosi_pin(mosi_pin), .serial_miso_pin(miso_pin),
        .serial_ss_pin(ss_pin), .serial_periph_enable(spe_o), .serial_periph_master_select(mstr_o),
        .timer1_ch0_edge_level_select(els), .timer1_ch1_edge_level_select(els1),
        .timer2_ch0_edge_level_select(els2), .timer2_ch1_edge_level_select(els3),
        .timer_ch_out(t_out), .timer_ch_oe(t_oe), .timer1_channel0_pin(t_pin[0]),
        .timer1_channel1_pin(t_pin[1]), .timer2_channel0_pin(t_pin[2]), .timer2_channel1_pin(t_pin[3]));
    pio_pin_model #(.W(8)) u_pin_b (.clk_sys, .pin_out(b_out), .pin_oe(b_oe), .pullup_on(8'h00),
        .ext_val(8'hF0), .ext_en(~b_oe), .pin_level(b_lvl));
    pio_pin_model #(.W(7)) u_pin_c (.clk_sys, .pin_out(c_out), .pin_oe(c_oe), .pullup_on(c_pu),
        .ext_val(c_ext), .ext_en(c_ext_en), .pin_level(c_lvl));
    pio_pin_model #(.W(8)) u_pin_d (.clk_sys, .pin_out(d_out), .pin_oe(d_oe), .pullup_on(d_pu),
        .ext_val(d_ext), .ext_en(d_ext_en), .pin_level(d_lvl));

    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {6'h00, idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        `CHK(q, exp)
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clk_sys);
        failures++;
        end_sim();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`PIO_IDX_PORTB_DIR, 32'h0);
        rd(`PIO_IDX_PORTD_DIR, 32'h0);
        wr(`PIO_IDX_PORTC_LATCH, 8'h8A);
        wr(`PIO_IDX_PORTD_LATCH, 8'h05);
        wr(`PIO_IDX_PORTC_DIR, 8'h01);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        `CHK(c_oe, 7'h00)
        `CHK(d_oe, 8'h00)
        wr(`PIO_IDX_PORTB_LATCH, 8'h3C);
        wr(`PIO_IDX_PORTB_DIR, 8'h0F);
        @(negedge clk_sys);
        `CHK(b_oe, 8'h0F)
        rd(`PIO_IDX_PORTB_LATCH, 32'hFC);
        wr(`PIO_IDX_PORTB_LATCH, 8'hC3);
        rd(`PIO_IDX_PORTB_LATCH, 32'hF3);
        wr(`PIO_IDX_PORTC_PUE, 8'h7F);
        wr(`PIO_IDX_PORTC_DIR, 8'h9F);
        rd(`PIO_IDX_PORTC_DIR, 32'h1F);
        `CHK(c_pu, 7'h60)
        rd(`PIO_IDX_PORTC_LATCH, 32'h6A);
        wr(`PIO_IDX_PORTD_PUE, 8'hF0);
        wr(`PIO_IDX_PORTD_DIR, 8'h0F);
        @(negedge clk_sys);
        `CHK(d_oe, 8'h0F)
        `CHK(d_pu, 8'hF0)
        rd(`PIO_IDX_PORTD_LATCH, 32'hF5);
        miso_oe <= 1'b1;
        wr(`PIO_IDX_PERIPH_CTRL, 8'h01);
        @(negedge clk_sys);
        `CHK(d_oe[3:0], 4'h2)
        `CHK({mstr_o, spe_o}, 2'h1)
        rd(`PIO_IDX_PORTD_LATCH, 32'hF5);
        wr(`PIO_IDX_PERIPH_CTRL, 8'h03);
        @(negedge clk_sys);
        `CHK(d_oe[3:0], 4'h3)
        `CHK({mstr_o, spe_o}, 2'h3)
        @(posedge clk_sys);
        els <= 2'h1;
        els1 <= 2'h1;
        els2 <= 2'h2;
        els3 <= 2'h3;
        t_oe <= 4'hF;
        t_out <= 4'h5;
        mosi_out <= 1'b1;
        mosi_oe <= 1'b1;
        miso_out <= 1'b1;
        d_ext_en <= 8'h08;
        c_ext_en <= 7'h60;
        c_ext <= 7'h20;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(d_oe, 8'hF7)
        `CHK(d_out, 8'h57)
        `CHK(d_pu, 8'h00)
        `CHK(t_pin, 4'h5)
        `CHK({sck_pin, mosi_pin, miso_pin, ss_pin}, 4'h7)
        rd(`PIO_IDX_PORTD_LATCH, 32'h55);
        rd(`PIO_IDX_PORTC_LATCH, 32'h2A);
        clk_en <= 1'b0;
        wr(`PIO_IDX_PORTB_DIR, 8'hFF);
        clk_en <= 1'b1;
        rd(`PIO_IDX_PORTB_DIR, 32'h0F);
        pstrb <= 4'hE;
        wr(`PIO_IDX_PORTB_DIR, 8'hFF);
        pstrb <= 4'hF;
        wr(4'hF, 8'hFF);
        rd(4'hF, 32'h0);
        `CHK(last_err, 1'b1)
        rd(`PIO_IDX_PORTB_DIR, 32'h0F);
        `CHK(last_err, 1'b0)
        end_sim();
    end
endmodule // tb
`default_nettype wire
